// >>> rtl/uart_pkg.sv
package uart_pkg;
  // ==========================================
  // Bus and storage geometry
  localparam int ADDR_W = 8;
  localparam int ENTRY_W = 11;
  localparam int PTR_W = 4;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] FIFO_DEPTH = 5'h10;
  localparam logic [CNT_W-1:0] HOLD_DEPTH = 5'h01;

  // ==========================================
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_DATA = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_IRQ_EN = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_IDENT = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_LINE = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_PWR = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_EVT = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_MASK = 8'h18;

  // ==========================================
  // Field positions
  localparam int CTL_FIFO_EN = 0;
  localparam int CTL_RX_CLR = 1;
  localparam int CTL_TX_CLR = 2;
  localparam int CTL_DMA = 3;
  localparam int CTL_TRIG_LO = 6;
  localparam int IEN_RDA = 0;
  localparam int IEN_THRE = 1;
  localparam int IEN_LS = 2;
  localparam int PWR_RX_RUN = 0;
  localparam int LINE_OE = 1;
  localparam int EVT_LS = 0;
  localparam int EVT_CTO = 2;
  localparam int ERR_PE = 8;
  localparam int ERR_BI = 10;

  // ==========================================
  // Reset values
  localparam logic [1:0] TRIG_RESET = 2'h0;
  localparam logic [2:0] IEN_RESET = 3'h0;
  localparam logic [3:0] EVT_RESET = 4'h0;

  // ==========================================
  // Identification codes and timing
  localparam logic [3:0] ID_NONE = 4'h1;
  localparam logic [3:0] ID_LS = 4'h6;
  localparam logic [3:0] ID_RDA = 4'h4;
  localparam logic [3:0] ID_CTO = 4'hc;
  localparam logic [3:0] ID_THRE = 4'h2;
  localparam logic [1:0] ID_FIFO_MODE = 2'h3;
  localparam logic [2:0] TIMEOUT_CHARS = 3'h4;

  function automatic logic [CNT_W-1:0] trig_depth(input logic [1:0] sel);
    unique case (sel)
      2'h0: trig_depth = 5'h01;
      2'h1: trig_depth = 5'h04;
      2'h2: trig_depth = 5'h08;
      2'h3: trig_depth = 5'h0e;
    endcase
  endfunction
endpackage

// >>> rtl/fifo_if.sv
`timescale 1ns/100ps
interface fifo_if;
  logic push;
  logic pop;
  logic clear;
  logic [uart_pkg::ENTRY_W-1:0] wdata;
  logic [uart_pkg::ENTRY_W-1:0] rdata;
  logic [uart_pkg::CNT_W-1:0] count;
  logic [uart_pkg::CNT_W-1:0] limit;
  logic full;
  logic empty;
  modport owner(output push, pop, clear, wdata, limit, input rdata, count, full, empty);
  modport store(input push, pop, clear, wdata, limit, output rdata, count, full, empty);
endinterface

// >>> rtl/uart_fifo.sv
`timescale 1ns/100ps
module uart_fifo (
  input wire logic clock,
  input wire logic rst,
  fifo_if.store port
);
  logic [uart_pkg::ENTRY_W-1:0] mem [16];
  logic [uart_pkg::PTR_W-1:0] wr_ptr;
  logic [uart_pkg::PTR_W-1:0] rd_ptr;
  logic do_push;
  logic do_pop;

  // Limit of one turns the store into a plain holding register
  assign port.full = port.count >= port.limit;
  assign port.empty = port.count == 5'h00;
  assign port.rdata = mem[rd_ptr];
  assign do_push = port.push & ~port.full;
  assign do_pop = port.pop & ~port.empty;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_ptr <= 4'h0;
      rd_ptr <= 4'h0;
      port.count <= 5'h00;
    end else if (port.clear) begin // [RQ14] [RQ15]
      wr_ptr <= 4'h0;
      rd_ptr <= 4'h0;
      port.count <= 5'h00;
    end else begin
      wr_ptr <= wr_ptr + 4'(do_push);
      rd_ptr <= rd_ptr + 4'(do_pop);
      port.count <= port.count + 5'(do_push) - 5'(do_pop);
    end
  end

  always_ff @(posedge clock) begin
    if (do_push) begin
      mem[wr_ptr] <= port.wdata;
    end
  end

  AST_CLEAR_EMPTIES: assert property (@(posedge clock) disable iff (rst) // [RQ14]
    port.clear |=> port.count == 5'h00 && wr_ptr == rd_ptr)
    else $error("Clear left the store non-empty");
  AST_COUNT_BOUND: assert property (@(posedge clock) disable iff (rst)
    port.count <= uart_pkg::FIFO_DEPTH)
    else $error("Store count beyond depth");
endmodule

// >>> rtl/uart_irq_encoder.sv
`timescale 1ns/100ps
module uart_irq_encoder (
  input wire logic clock,
  input wire logic rst,
  input wire logic line_status,
  input wire logic data_ready,
  input wire logic char_timeout,
  input wire logic tx_empty,
  input wire logic fifo_mode,
  output logic [7:0] ident
);
  logic [3:0] code;

  always_comb begin
    if (line_status) begin // [RQ1] [RQ17]
      code = uart_pkg::ID_LS;
    end else if (char_timeout) begin // [RQ5]
      code = uart_pkg::ID_CTO;
    end else if (data_ready) begin // [RQ3]
      code = uart_pkg::ID_RDA;
    end else if (tx_empty) begin // [RQ7]
      code = uart_pkg::ID_THRE;
    end else begin
      code = uart_pkg::ID_NONE;
    end
  end

  assign ident = {fifo_mode ? uart_pkg::ID_FIFO_MODE : 2'h0, 2'h0, code}; // [RQ16]

  AST_MODE_FIELD: assert property (@(posedge clock) disable iff (rst) // [RQ16]
    ident[7:6] == (fifo_mode ? 2'h3 : 2'h0))
    else $error("Mode field does not follow fifo mode");
  AST_PRIORITY: assert property (@(posedge clock) disable iff (rst) // [RQ17]
    (line_status |-> ident[3:0] == 4'h6) and
    (!line_status && !char_timeout && !data_ready && tx_empty |-> ident[3:0] == 4'h2) and
    (!line_status && !char_timeout && !data_ready && !tx_empty |-> ident[3:0] == 4'h1))
    else $error("Wrong interrupt reported");
endmodule

// >>> rtl/uart_irq_id_fifo_ctrl.sv
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/100ps
// What this block does
// RQ1: Overrun, parity, framing or break raises line status interrupt, code 0110.
// RQ2: Overrun cause clears on status read; data errors clear once all read out.
// RQ3: Without FIFOs, character available raises data-ready, code 0100; data read clears.
// RQ4: With FIFOs, data-ready follows trigger level; re-raised after four idle character times.
// RQ5: With FIFOs, data held and four idle character times raise timeout, code 1100.
// RQ6: Timeout clears on FIFO read, new arrival, or receiver reset written zero.
// RQ7: Empty holding register or transmit FIFO raises code 0010; a write clears.
// RQ8: Data-ready or timeout clears on first receive read, CPU or DMA.
// RQ9: One address: reads give identification, writes go to FIFO control.
// RQ10: FIFO enable must be set first; other control fields ignored otherwise.
// RQ11: Software always writes DMA mode one, moving it from zero after reset.
// RQ12: Clear bits act on writing one, never hold state, zero does nothing.
// RQ13: Trigger field selects 1, 4, 8 or 14 bytes.
// RQ14: A clear bit empties its FIFO and counter, shifters untouched.
// RQ15: Clearing FIFO enable disables and empties both FIFOs.
// RQ16: Identification bits 7-6 read 3 with FIFOs enabled, else 0.
// RQ17: Highest priority pending source reported; 0001 when none pending.
// RQ18: Control fields reset to zero; reserved bits read zero, ignore writes.
module uart_irq_id_fifo_ctrl (
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [uart_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_push,
  input wire logic [7:0] rx_char,
  input wire logic rx_parity_err,
  input wire logic rx_frame_err,
  input wire logic rx_break,
  input wire logic char_tick,
  input wire logic tx_take,
  output logic [7:0] tx_char,
  output logic tx_char_valid,
  input wire logic dma_rx_pop,
  input wire logic dma_tx_push,
  input wire logic [7:0] dma_tx_data,
  output logic [7:0] rx_head,
  output logic dma_rx_req,
  output logic dma_tx_req,
  output logic dma_mode,
  output logic receiver_enable,
  output logic irq
);
  fifo_if rx_if();
  fifo_if tx_if();

  logic acc;
  logic done;
  logic rd_done;
  logic addr_hit;
  logic ctrl_wr;
  logic ctrl_apply;
  logic fifo_disable;
  logic fifo_en;
  logic [1:0] trig_sel;
  logic [2:0] irq_enable;
  logic receiver_reset_bit;
  logic [3:0] evt_status;
  logic [3:0] evt_mask;
  logic [3:0] evt_src;
  logic [3:0] evt_src_q;
  logic [31:0] next_prdata;
  logic [7:0] ident;
  logic [7:0] line_status_reg;
  logic cpu_tx_write;
  logic rx_accept;
  logic pushed;
  logic rx_pop;
  logic overrun_evt;
  logic overrun;
  logic [uart_pkg::CNT_W-1:0] err_count;
  logic [2:0] idle_cnt;
  logic idle_hit;
  logic rda_lvl;
  logic rda_lvl_q;
  logic rda_flag;
  logic cto_flag;
  logic rxrst_zero_wr;
  logic ls_p;
  logic rda_p;
  logic cto_p;
  logic thre_p;

  // ==========================================
  // APB slave with one wait state, so read data leaves a flip-flop
  assign acc = psel & penable;
  assign done = acc & pready;
  assign rd_done = done & ~pwrite;

  always_comb begin
    unique case (paddr)
      uart_pkg::OFF_DATA, uart_pkg::OFF_IRQ_EN, uart_pkg::OFF_IDENT, uart_pkg::OFF_LINE,
      uart_pkg::OFF_PWR, uart_pkg::OFF_EVT, uart_pkg::OFF_MASK: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  end

  assign pslverr = done & ~addr_hit;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
    end else begin
      pready <= acc & ~pready;
    end
  end

  // Reserved bits stay zero in every word read back
  always_comb begin
    next_prdata = 32'h0000_0000;
    unique case (paddr)
      uart_pkg::OFF_DATA: next_prdata[7:0] = rx_if.rdata[7:0];
      uart_pkg::OFF_IRQ_EN: next_prdata[2:0] = irq_enable;
      uart_pkg::OFF_IDENT: next_prdata[7:0] = ident; // [RQ9]
      uart_pkg::OFF_LINE: next_prdata[7:0] = line_status_reg;
      uart_pkg::OFF_PWR: next_prdata[uart_pkg::PWR_RX_RUN] = receiver_reset_bit;
      uart_pkg::OFF_EVT: next_prdata[3:0] = evt_status;
      uart_pkg::OFF_MASK: next_prdata[3:0] = evt_mask;
      default: next_prdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (acc & ~pready & ~pwrite) begin
      prdata <= next_prdata;
    end
  end

  // ==========================================
  // FIFO control, write side of the identification address
  assign ctrl_wr = done & pwrite & (paddr == uart_pkg::OFF_IDENT); // [RQ9]
  assign ctrl_apply = ctrl_wr & fifo_en & pwdata[uart_pkg::CTL_FIFO_EN]; // [RQ10]
  assign fifo_disable = ctrl_wr & fifo_en & ~pwdata[uart_pkg::CTL_FIFO_EN];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fifo_en <= 1'b0; // [RQ18]
      trig_sel <= uart_pkg::TRIG_RESET;
      dma_mode <= 1'b0; // [RQ11]
    end else begin
      if (ctrl_wr) begin
        fifo_en <= pwdata[uart_pkg::CTL_FIFO_EN];
      end
      if (ctrl_apply) begin // [RQ10]
        trig_sel <= pwdata[uart_pkg::CTL_TRIG_LO +: 2];
        dma_mode <= pwdata[uart_pkg::CTL_DMA];
      end
    end
  end

  // Clear bits are pulses only; nothing of them is stored
  assign rx_if.clear = (ctrl_apply & pwdata[uart_pkg::CTL_RX_CLR]) | fifo_disable; // [RQ12] [RQ14] [RQ15]
  assign tx_if.clear = (ctrl_apply & pwdata[uart_pkg::CTL_TX_CLR]) | fifo_disable; // [RQ12] [RQ14] [RQ15]
  assign rx_if.limit = fifo_en ? uart_pkg::FIFO_DEPTH : uart_pkg::HOLD_DEPTH;
  assign tx_if.limit = fifo_en ? uart_pkg::FIFO_DEPTH : uart_pkg::HOLD_DEPTH;

  // ==========================================
  // Other software registers
  assign rxrst_zero_wr = done & pwrite & (paddr == uart_pkg::OFF_PWR) & ~pwdata[uart_pkg::PWR_RX_RUN];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_enable <= uart_pkg::IEN_RESET;
      receiver_reset_bit <= 1'b0;
      evt_mask <= uart_pkg::EVT_RESET;
    end else if (done & pwrite) begin
      if (paddr == uart_pkg::OFF_IRQ_EN) begin
        irq_enable <= pwdata[2:0];
      end
      if (paddr == uart_pkg::OFF_PWR) begin
        receiver_reset_bit <= pwdata[uart_pkg::PWR_RX_RUN];
      end
      if (paddr == uart_pkg::OFF_MASK) begin
        evt_mask <= pwdata[3:0];
      end
    end
  end

  assign receiver_enable = receiver_reset_bit;

  // ==========================================
  // Receive path
  uart_fifo rx_store (
    .clock(clock),
    .rst(rst),
    .port(rx_if.store)
  );

  assign rx_accept = rx_push & receiver_reset_bit;
  assign overrun_evt = rx_accept & rx_if.full;
  assign pushed = rx_accept & ~rx_if.full;
  assign rx_pop = (dma_rx_pop | (rd_done & (paddr == uart_pkg::OFF_DATA))) & ~rx_if.empty;
  assign rx_if.push = rx_accept;
  assign rx_if.pop = rx_pop;
  assign rx_if.wdata = {rx_break, rx_frame_err, rx_parity_err, rx_char};
  assign rx_head = rx_if.rdata[7:0];
  assign dma_rx_req = dma_mode & ~rx_if.empty;

  // Only the overrun seen by the read is cleared; a new one in between survives
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      overrun <= 1'b0;
    end else begin
      overrun <= overrun_evt | (overrun & ~(rd_done & (paddr == uart_pkg::OFF_LINE) & prdata[uart_pkg::LINE_OE])); // [RQ2]
    end
  end

  // Erroneous characters still waiting keep the line status cause alive
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      err_count <= 5'h00;
    end else if (rx_if.clear) begin
      err_count <= 5'h00;
    end else begin
      err_count <= err_count + 5'(pushed & (|rx_if.wdata[uart_pkg::ERR_BI:uart_pkg::ERR_PE]))
        - 5'(rx_pop & (|rx_if.rdata[uart_pkg::ERR_BI:uart_pkg::ERR_PE])); // [RQ2]
    end
  end

  assign line_status_reg = {err_count != 5'h00, tx_if.empty, tx_if.empty,
    rx_if.rdata[uart_pkg::ERR_BI:uart_pkg::ERR_PE], overrun, ~rx_if.empty};

  // ==========================================
  // Character-time idle watch
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      idle_cnt <= 3'h0;
    end else if (pushed | rx_pop | rx_if.clear | ~fifo_en | rxrst_zero_wr) begin // Receiver reset restarts the watch [RQ6]
      idle_cnt <= 3'h0;
    end else if (char_tick & (idle_cnt != uart_pkg::TIMEOUT_CHARS)) begin
      idle_cnt <= idle_cnt + 3'h1;
    end
  end

  assign idle_hit = char_tick & ~pushed & ~rx_pop & fifo_en & (idle_cnt == uart_pkg::TIMEOUT_CHARS - 3'h1);

  // ==========================================
  // Receive interrupt causes
  assign rda_lvl = fifo_en ? (rx_if.count >= uart_pkg::trig_depth(trig_sel)) : ~rx_if.empty; // [RQ3] [RQ13]

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rda_lvl_q <= 1'b0;
      rda_flag <= 1'b0;
    end else begin
      rda_lvl_q <= rda_lvl;
      if (rda_lvl & (~rda_lvl_q | idle_hit)) begin // [RQ4]
        rda_flag <= 1'b1;
      end else if (~rda_lvl | rx_pop) begin // [RQ4] [RQ8]
        rda_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cto_flag <= 1'b0;
    end else if (idle_hit & ~rx_if.empty) begin // [RQ5]
      cto_flag <= 1'b1;
    end else if (rx_pop | pushed | rxrst_zero_wr | rx_if.clear | ~fifo_en) begin // [RQ6] [RQ8]
      cto_flag <= 1'b0;
    end
  end

  assign ls_p = irq_enable[uart_pkg::IEN_LS] & (overrun | (err_count != 5'h00)); // [RQ1]
  assign rda_p = irq_enable[uart_pkg::IEN_RDA] & (fifo_en ? rda_flag : rda_lvl);
  assign cto_p = irq_enable[uart_pkg::IEN_RDA] & cto_flag;
  assign thre_p = irq_enable[uart_pkg::IEN_THRE] & tx_if.empty; // [RQ7]

  uart_irq_encoder encoder (
    .clock(clock),
    .rst(rst),
    .line_status(ls_p),
    .data_ready(rda_p),
    .char_timeout(cto_p),
    .tx_empty(thre_p),
    .fifo_mode(fifo_en),
    .ident(ident)
  );

  // ==========================================
  // Transmit path
  uart_fifo tx_store (
    .clock(clock),
    .rst(rst),
    .port(tx_if.store)
  );

  assign cpu_tx_write = done & pwrite & (paddr == uart_pkg::OFF_DATA);
  assign tx_if.push = cpu_tx_write | dma_tx_push; // [RQ7]
  assign tx_if.wdata = {3'h0, cpu_tx_write ? pwdata[7:0] : dma_tx_data};
  assign tx_if.pop = tx_take & ~tx_if.empty;
  assign tx_char = tx_if.rdata[7:0];
  assign tx_char_valid = ~tx_if.empty;
  assign dma_tx_req = dma_mode & ~tx_if.full;

  // ==========================================
  // Sticky events, cleared by reading what was seen
  assign evt_src = {thre_p, cto_p, rda_p, ls_p};

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      evt_src_q <= 4'h0;
      evt_status <= uart_pkg::EVT_RESET;
    end else begin
      evt_src_q <= evt_src;
      evt_status <= (evt_src & ~evt_src_q) |
        (evt_status & ~((rd_done & (paddr == uart_pkg::OFF_EVT)) ? prdata[3:0] : 4'h0));
    end
  end

  assign irq = |(evt_status & evt_mask);

  // ==========================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  AST_LS_ON_OVERRUN: assert property (overrun_evt && irq_enable[2] |=> ident[3:0] == 4'h6) // [RQ1]
    else $error("Overrun did not raise line status");
  AST_OVERRUN_CLEAR: assert property (rd_done && paddr == 8'h0c && prdata[1] && !overrun_evt |=> !overrun) // [RQ2]
    else $error("Status read left overrun set");
  AST_HOLD_RDA: assert property (!fifo_en && pushed && irq_enable[0] |=> ident[3:0] == (ls_p ? 4'h6 : 4'h4)) // [RQ3]
    else $error("Held character did not raise data ready");
  AST_BELOW_TRIGGER: assert property ((fifo_en && !rda_lvl)[*2] |-> !rda_flag) // [RQ4]
    else $error("Data ready held below trigger");
  AST_CTO_SET: assert property (idle_hit && !rx_if.empty |=> cto_flag) // [RQ5]
    else $error("Timeout not raised after idle");
  AST_CTO_CLEAR: assert property (cto_flag && (pushed || rx_pop || rxrst_zero_wr) |=> !cto_flag) // [RQ6]
    else $error("Timeout not cleared");
  AST_THRE_CLEAR: assert property (tx_if.push && !tx_if.full |=> !tx_if.empty ##0 ident[3:0] != 4'h2) // [RQ7]
    else $error("Transmit empty survived a write");
  AST_FIRST_READ: assert property (fifo_en && rda_flag && rx_pop |=> !rda_flag) // [RQ8]
    else $error("First read did not clear data ready");
  AST_CTRL_IGNORED: assert property (ctrl_wr && !fifo_en |=> $stable(trig_sel) && $stable(dma_mode)) // [RQ10]
    else $error("Control field taken without fifo enable");
  AST_DISABLE_EMPTIES: assert property (fifo_disable |=> rx_if.count == 5'h00 && tx_if.count == 5'h00) // [RQ15]
    else $error("Disable left data in a FIFO");

  COV_TIMEOUT: cover property (idle_hit && !rx_if.empty ##1 cto_p);
  COV_OVERRUN: cover property (overrun_evt);
  COV_CTRL_APPLY: cover property (ctrl_apply && pwdata[1]);
  COV_IRQ: cover property ($rose(irq));
endmodule

// >>> dv/line_model.sv
`timescale 1ns/100ps
// ==========================================
// Far side: receive shifter, character timer, transmit shifter, DMA reader
module line_model (
  input wire logic clock,
  input wire logic tx_char_valid,
  input wire logic dma_rx_req,
  output logic rx_push,
  output logic [7:0] rx_char,
  output logic rx_parity_err,
  output logic rx_frame_err,
  output logic rx_break,
  output logic char_tick,
  output logic tx_take,
  output logic dma_rx_pop
);
  initial begin
    rx_push = 1'b0;
    rx_char = 8'h00;
    {rx_break, rx_frame_err, rx_parity_err} = 3'h0;
    char_tick = 1'b0;
    tx_take = 1'b0;
    dma_rx_pop = 1'b0;
  end

  // ==========================================
  // Strobes
  // Released lines show the inverse so a stale value never passes for a fresh one
  task automatic send(input logic [7:0] c, input logic [2:0] e);
    @(posedge clock);
    rx_push <= 1'b1;
    rx_char <= c;
    {rx_break, rx_frame_err, rx_parity_err} <= e;
    @(posedge clock);
    rx_push <= 1'b0;
    rx_char <= ~c;
    {rx_break, rx_frame_err, rx_parity_err} <= ~e;
  endtask

  task automatic ticks(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clock);
      char_tick <= 1'b1;
      @(posedge clock);
      char_tick <= 1'b0;
    end
  endtask

  task automatic take();
    @(posedge clock);
    tx_take <= tx_char_valid;
    @(posedge clock);
    tx_take <= 1'b0;
  endtask

  // DMA reads only while it is asked to
  task automatic dma_pop();
    @(posedge clock);
    dma_rx_pop <= dma_rx_req;
    @(posedge clock);
    dma_rx_pop <= 1'b0;
  endtask
endmodule

// >>> dv/uart_irq_id_fifo_ctrl_test.sv
`timescale 1ns/100ps
module uart_irq_id_fifo_ctrl_test;
  logic clock, rst, psel, penable, pwrite, pready, pslverr, sp;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic rx_push, rx_parity_err, rx_frame_err, rx_break, char_tick, tx_take, dma_rx_pop, dma_tx_push;
  logic [7:0] rx_char, tx_char, rx_head, dma_tx_data;
  logic tx_char_valid, dma_rx_req, dma_tx_req, dma_mode, receiver_enable, irq;
  int err_count = 0;
  int num_checks = 0;
  int lvl [4] = '{1, 4, 8, 14};
  logic [31:0] f;

  uart_irq_id_fifo_ctrl DUT (.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .rx_push, .rx_char, .rx_parity_err, .rx_frame_err, .rx_break, .char_tick, .tx_take,
    .tx_char, .tx_char_valid, .dma_rx_pop, .dma_tx_push, .dma_tx_data, .rx_head, .dma_rx_req,
    .dma_tx_req, .dma_mode, .receiver_enable, .irq);
  line_model line (.clock, .tx_char_valid, .dma_rx_req, .rx_push, .rx_char, .rx_parity_err,
    .rx_frame_err, .rx_break, .char_tick, .tx_take, .dma_rx_pop);

  // ==========================================
  // Bus and compare tasks
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Starts one edge late so a released strobe is never raised in the same step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge clock);
    end
    if (n == 50) check("pready", 32'h0, 32'h1);
    rd = prdata;
    sp = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Completion edge updates land in its own step; callers look one edge later
    @(posedge clock);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check($sformatf("reg %h", a), rd & m, e);
  endtask

  task automatic id(input logic [31:0] e, input logic [31:0] m = 32'hffffffff);
    rd_chk(uart_pkg::OFF_IDENT, m, e);
  endtask

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  initial begin
    #500000;
    err_count++;
    summarize();
  end

  // ==========================================
  // Tests
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, dma_tx_push} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    dma_tx_data = 8'h00;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    id(32'h01);
    apb(1'b1, uart_pkg::OFF_IDENT, 32'h48);
    check("dma_mode", dma_mode, 1'b0);
    apb(1'b1, uart_pkg::OFF_MASK, 32'h8);
    apb(1'b1, uart_pkg::OFF_IRQ_EN, 32'h7);
    id(32'h02);
    check("irq", irq, 1'b1);
    rd_chk(uart_pkg::OFF_EVT, 32'h8, 32'h8);
    @(posedge clock);
    check("irq", irq, 1'b0);
    apb(1'b0, 8'h1c, 32'h0);
    check("pslverr", sp, 1'b1);
    $display("test reset and irq done");
    apb(1'b1, uart_pkg::OFF_DATA, 32'h3c);
    id(32'h01);
    check("tx_char", tx_char, 8'h3c);
    check("tx_char_valid", tx_char_valid, 1'b1);
    line.take();
    id(32'h02);
    check("tx_char_valid", tx_char_valid, 1'b0);
    $display("test transmit done");
    apb(1'b1, uart_pkg::OFF_PWR, 32'h1);
    line.send(8'h5a, 3'h0);
    line.ticks(4);
    id(32'h04);
    check("rx_head", rx_head, 8'h5a);
    line.send(8'ha5, 3'h0);
    id(32'h06);
    rd_chk(uart_pkg::OFF_LINE, 32'h2, 32'h2);
    id(32'h04);
    rd_chk(uart_pkg::OFF_DATA, 32'hff, 32'h5a);
    id(32'h02);
    $display("test non-FIFO receive done");
    apb(1'b1, uart_pkg::OFF_IDENT, 32'h1);
    id(32'hc2);
    apb(1'b1, uart_pkg::OFF_IDENT, 32'h9);
    check("dma_mode", dma_mode, 1'b1);
    check("dma_tx_req", dma_tx_req, 1'b1);
    @(posedge clock);
    dma_tx_data <= 8'h77;
    dma_tx_push <= 1'b1;
    @(posedge clock);
    dma_tx_push <= 1'b0;
    id(32'hc1);
    check("tx_char", tx_char, 8'h77);
    line.take();
    for (int i = 0; i < 4; i++) begin
      f = (i << 6) | 32'h9;
      apb(1'b1, uart_pkg::OFF_IDENT, f);
      repeat (lvl[i] - 1) line.send(8'h40 + i, 3'h0);
      id(32'hc2);
      line.send(8'h50, 3'h0);
      id(32'hc4);
      check("dma_rx_req", dma_rx_req, 1'b1);
      apb(1'b1, uart_pkg::OFF_IDENT, f);
      id(32'hc4);
      line.dma_pop();
      id(32'hc2);
      apb(1'b1, uart_pkg::OFF_IDENT, f | 32'h2);
      id(32'hc2);
      check("dma_rx_req", dma_rx_req, 1'b0);
    end
    $display("test trigger levels done");
    line.send(8'h11, 3'h0);
    line.ticks(4);
    id(32'hcc);
    line.send(8'h22, 3'h0);
    id(32'h0, 32'h8);
    line.ticks(4);
    id(32'hcc);
    apb(1'b1, uart_pkg::OFF_PWR, 32'h0);
    id(32'h0, 32'h8);
    check("receiver_enable", receiver_enable, 1'b0);
    apb(1'b1, uart_pkg::OFF_PWR, 32'h1);
    line.ticks(4);
    id(32'hcc);
    line.dma_pop();
    id(32'h0, 32'h8);
    rd_chk(uart_pkg::OFF_DATA, 32'hff, 32'h22);
    id(32'hc2);
    $display("test timeout done");
    for (int e = 1; e < 8; e = e * 2) begin
      line.send(8'h33, e[2:0]);
      id(32'hc6);
      apb(1'b0, uart_pkg::OFF_LINE, 32'h0);
      id(32'hc6);
      apb(1'b0, uart_pkg::OFF_DATA, 32'h0);
      id(32'hc2);
    end
    $display("test line errors done");
    line.send(8'h61, 3'h0);
    line.send(8'h62, 3'h0);
    apb(1'b1, uart_pkg::OFF_IDENT, 32'h0);
    id(32'h02);
    check("dma_rx_req", dma_rx_req, 1'b0);
    $display("test FIFO disable done");
    summarize();
  end
endmodule
